// ### hw/switch_cfg_pkg.sv
// Shared constants and carrier types of the switch configuration subsystem
package switch_cfg_pkg;

	// ****************************************************************
	// Build-time defaults
	// ****************************************************************
	localparam int          PORT_HIGH_DEFAULT      = 4;
	localparam int          PORT_MAX               = 8;
	localparam logic [15:0] PORT_STATE_DEFAULT     = 16'h0120;
	localparam int          QUEUE_COUNT_DEFAULT    = 4;
	localparam logic [7:0]  RING_MASK_DEFAULT      = 8'h0e;
	localparam logic [7:0]  PARALLEL_MASK_DEFAULT  = 8'h0e;
	localparam logic [7:0]  CUT_THROUGH_DEFAULT    = 8'h06;
	localparam int          POLICING_DEFAULT       = 0;
	localparam int          POLICER_BITS_DEFAULT   = 7;
	localparam int          ADDR_TOP_DEFAULT       = 20;
	localparam logic [4:0]  MDIO_ADDR_DEFAULT      = 5'h01;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam longint      CLOCK_HZ               = 125_000_000;
	localparam longint      CLOCK_PERIOD_NS        = 8;
	localparam longint      PPS_PERIOD_NS          = 1_000_000_000;
	localparam int          PPS_PERIOD_CYCLES      = int'(PPS_PERIOD_NS / CLOCK_PERIOD_NS);

	// ****************************************************************
	// Word address map, relative to the subsystem base
	// ****************************************************************
	localparam logic [31:0] SWITCH_OFFSET          = 32'h0001_0000;
	localparam logic [PORT_MAX-1:0][31:0] PORT_BASE_DEFAULT = {
		32'h0, 32'h0, 32'h0, 32'h0007_0000,
		32'h0006_0000, 32'h0005_0000, 32'h0004_0000, 32'h0012_0000};
	localparam logic [PORT_MAX-1:0][31:0] ADAPTER_BASE_DEFAULT = {
		32'h0, 32'h0, 32'h0, 32'h0002_0800,
		32'h0002_0600, 32'h0002_0400, 32'h0002_0200, 32'h000a_0000};
	localparam int          GROUP_LSB              = 12;
	localparam int          GROUP_COUNT            = 5;
	localparam logic [2:0]  GROUP_GENERAL          = 3'h0;
	localparam logic [2:0]  GROUP_RING             = 3'h1;
	localparam logic [2:0]  GROUP_TIME             = 3'h2;
	localparam logic [2:0]  GROUP_COUNTER          = 3'h3;
	localparam logic [2:0]  GROUP_PRIORITY         = 3'h4;
	localparam logic [11:0] SW_CONFIG_WORD         = 12'h000;
	localparam logic [11:0] SW_CONTROL_WORD        = 12'h001;

	// ****************************************************************
	// Field layouts and reset values
	// ****************************************************************
	localparam int          CFG_PORT_HIGH_LSB      = 0;
	localparam int          CFG_QUEUES_LSB         = 4;
	localparam int          CFG_POLICING_LSB       = 8;
	localparam int          CFG_COUNTERS_BIT       = 10;
	localparam int          CTRL_CUT_THROUGH_LSB   = 0;
	localparam int          CTRL_RTC_START_BIT     = 8;
	localparam int          CTRL_POLICE_STATIC_MAC_TABLE_BIT   = 9;
	localparam logic [31:0] CTRL_RESET             = 32'h0000_0000;
	localparam int          RING_CAP_BIT           = 0;
	localparam int          PARALLEL_CAP_BIT       = 1;
	localparam logic [1:0]  POLICE_NONE            = 2'h0;
	localparam logic [1:0]  POLICE_PRIORITY        = 2'h1;
	localparam logic [1:0]  POLICE_STATIC_MAC      = 2'h2;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic        read;
		logic        write;
		logic [31:0] address;
		logic [31:0] writedata;
	} bus_req_type;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} bus_rsp_type;

endpackage

// ### hw/port_unit.sv
// One switch port: state register, optional counter and indicator drive
module port_unit
	import switch_cfg_pkg::*;
#(
	parameter logic [15:0] port_state_default  = PORT_STATE_DEFAULT,
	parameter bit          counters_enable     = 1'b1,
	parameter bit          indicator_polarity  = 1'b1,
	parameter bit          traffic_led_enable  = 1'b1
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Register access
	input  wire logic        i_state_write,
	input  wire logic [15:0] i_state_data,
	// Synchronised adapter status
	input  wire logic        i_link,
	input  wire logic        i_activity,
	// Outputs
	output logic      [15:0] o_state,
	output logic      [31:0] o_count,
	output logic             o_link_led,
	output logic             o_activity_led
);

	logic [15:0] next_state;
	logic        next_link_led;
	logic        next_activity_led;

	always_comb begin
		next_state        = i_state_write ? i_state_data : o_state;
		next_link_led     = indicator_polarity ? i_link : ~i_link;
		next_activity_led = traffic_led_enable ?
			(indicator_polarity ? i_activity : ~i_activity) : ~indicator_polarity;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_state        <= port_state_default;
			o_link_led     <= 1'b0;
			o_activity_led <= 1'b0;
		end else begin
			o_state        <= next_state;
			o_link_led     <= next_link_led;
			o_activity_led <= next_activity_led;
		end
	end

	// ****************************************************************
	// Statistics, left out entirely when not wanted to save logic
	// ****************************************************************
	generate
		if (counters_enable) begin : g_counter
			logic        activity_prev;
			logic [31:0] next_count;
			always_comb begin
				next_count = (i_activity && !activity_prev) ? o_count + 32'h1 : o_count;
			end
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					activity_prev <= 1'b0;
					o_count       <= 32'h0;
				end else begin
					activity_prev <= i_activity;
					o_count       <= next_count;
				end
			end
		end else begin : g_no_counter
			assign o_count = 32'h0;
		end
	endgenerate

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_state_write: assert property (i_state_write |=> o_state == $past(i_state_data))
		else $error("port state not stored");
	a_state_holds: assert property (!i_state_write |=> $stable(o_state))
		else $error("port state changed without write");
	a_counter_absent: assert property (!counters_enable |-> o_count == 32'h0)
		else $error("counter present while disabled");
	a_link_polarity: assert property (##1 o_link_led == (indicator_polarity ?
		$past(i_link) : ~$past(i_link)))
		else $error("link indicator polarity wrong");

endmodule

// ### hw/switch_cfg_subsystem.sv
// Switch subsystem configuration, two-master register decoder and port state
module switch_cfg_subsystem
	import switch_cfg_pkg::*;
#(
	parameter int                        port_high                     = PORT_HIGH_DEFAULT,
	parameter logic [15:0]               port_state_default            = PORT_STATE_DEFAULT,
	parameter bit                        counters_enable               = 1'b1,
	parameter int                        priority_queue_count          = QUEUE_COUNT_DEFAULT,
	parameter logic [7:0]                ring_redundancy_port_mask     = RING_MASK_DEFAULT,
	parameter logic [7:0]                parallel_redundancy_port_mask = PARALLEL_MASK_DEFAULT,
	parameter logic [7:0]                cut_through_port_mask         = CUT_THROUGH_DEFAULT,
	parameter int                        policing_mode                 = POLICING_DEFAULT,
	parameter int                        policer_count_bits            = POLICER_BITS_DEFAULT,
	parameter longint                    system_clock_hz_param         = CLOCK_HZ,
	parameter int                        bus_address_top_bit           = ADDR_TOP_DEFAULT,
	parameter bit                        indicator_polarity            = 1'b1,
	parameter bit                        slave_a_enable                = 1'b1,
	parameter bit                        slave_b_enable                = 1'b1,
	parameter bit                        traffic_led_enable            = 1'b1,
	parameter bit                        rtc_autostart                 = 1'b1,
	parameter bit                        pps_enable                    = 1'b1,
	parameter logic [4:0]                mdio_addr_default             = MDIO_ADDR_DEFAULT,
	parameter bit                        mdio_addr_ext_enable          = 1'b0,
	parameter int                        pps_period_cycles             = PPS_PERIOD_CYCLES,
	parameter logic [PORT_MAX-1:0][31:0] port_base                     = PORT_BASE_DEFAULT,
	parameter logic [PORT_MAX-1:0][31:0] adapter_base                  = ADAPTER_BASE_DEFAULT
) (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_arst_n,
	// Slave A, processor side
	input  wire switch_cfg_pkg::bus_req_type i_bus_a,
	output switch_cfg_pkg::bus_rsp_type    o_bus_a,
	// Slave B, MDIO bridge side
	input  wire switch_cfg_pkg::bus_req_type i_bus_b,
	output switch_cfg_pkg::bus_rsp_type    o_bus_b,
	// Adapter status pins
	input  wire logic [port_high:0]        i_link_up,
	input  wire logic [port_high:0]        i_activity,
	input  wire logic [4:0]                i_mdio_addr_ext,
	// Port controls and indicators
	output logic      [port_high:0][15:0]  o_port_state,
	output logic      [port_high:0]        o_link_led,
	output logic      [port_high:0]        o_activity_led,
	output logic      [port_high:0]        o_cut_through_ports,
	output logic      [1:0]                o_policing_select,
	// Real-time clock and management address
	output logic                           o_pps,
	output logic      [31:0]               o_rtc_seconds,
	output logic      [4:0]                o_mdio_phy_addr
);

	localparam int          PORTS     = port_high + 1;
	localparam logic [31:0] ADDR_MASK = 32'((64'h1 << (bus_address_top_bit + 1)) - 64'h1);
	localparam logic [31:0] POLICERS  = (policing_mode == 0) ? 32'h0 :
		32'(64'h1 << policer_count_bits);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (PORTS < 1 || PORTS > PORT_MAX) begin : g_bad_ports
			$error("port_high out of range");
		end
		if (priority_queue_count != 4 && priority_queue_count != 8) begin : g_bad_queues
			$error("priority_queue_count must be 4 or 8");
		end
		if (policing_mode < 0 || policing_mode > 3) begin : g_bad_police
			$error("policing_mode must be 0 to 3");
		end
		if (policer_count_bits < 0 || policer_count_bits > 31) begin : g_bad_policers
			$error("policer_count_bits out of range");
		end
		if (bus_address_top_bit < GROUP_LSB + 3 || bus_address_top_bit > 31) begin : g_bad_addr
			$error("bus_address_top_bit out of range");
		end
		if (pps_period_cycles < 3) begin : g_bad_pps
			$error("pps_period_cycles too small");
		end
	endgenerate

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************
	logic                rst_meta;
	logic                rst_n;
	logic [port_high:0]  link_meta;
	logic [port_high:0]  link_sync;
	logic [port_high:0]  act_meta;
	logic [port_high:0]  act_sync;
	logic [4:0]          mdio_meta;
	logic [4:0]          mdio_sync;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_meta <= '0;
			link_sync <= '0;
			act_meta  <= '0;
			act_sync  <= '0;
			mdio_meta <= 5'h0;
			mdio_sync <= 5'h0;
		end else begin
			link_meta <= i_link_up;
			link_sync <= link_meta;
			act_meta  <= i_activity;
			act_sync  <= act_meta;
			mdio_meta <= i_mdio_addr_ext;
			mdio_sync <= mdio_meta;
		end
	end

	// ****************************************************************
	// Ports
	// ****************************************************************
	logic [port_high:0]        state_write;
	logic [port_high:0][31:0]  port_count;
	bus_req_type               sel;
	logic [31:0]               ctrl;

	generate
		for (genvar p = 0; p < PORTS; p++) begin : g_port
			port_unit #(
				.port_state_default (port_state_default),
				.counters_enable    (counters_enable),
				.indicator_polarity (indicator_polarity),
				.traffic_led_enable (traffic_led_enable)
			) u_port (
				.i_clk          (i_clk),
				.i_rst_n        (rst_n),
				.i_state_write  (state_write[p]),
				.i_state_data   (sel.writedata[15:0]),
				.i_link         (link_sync[p]),
				.i_activity     (act_sync[p]),
				.o_state        (o_port_state[p]),
				.o_count        (port_count[p]),
				.o_link_led     (o_link_led[p]),
				.o_activity_led (o_activity_led[p])
			);
		end
	endgenerate

	// ****************************************************************
	// Arbitration and decode
	// ****************************************************************
	// A wins ties; each grant opens waitrequest for exactly one cycle
	logic         grant_a;
	logic         grant_b;
	logic [31:0]  word;
	logic [31:0]  off;
	logic [31:0]  rdata;
	logic         hit;
	logic         ctrl_write;

	always_comb begin
		grant_a     = slave_a_enable && (i_bus_a.read || i_bus_a.write) && o_bus_a.waitrequest;
		grant_b     = slave_b_enable && (i_bus_b.read || i_bus_b.write) && o_bus_b.waitrequest &&
			!grant_a;
		sel         = grant_a ? i_bus_a : i_bus_b;
		word        = sel.address & ADDR_MASK;
		off         = 32'h0;
		rdata       = 32'h0;
		hit         = 1'b0;
		ctrl_write  = 1'b0;
		state_write = '0;
		if ((word & 32'hffff_f000) == SWITCH_OFFSET) begin
			if (word[11:0] == SW_CONFIG_WORD) begin
				hit   = 1'b1;
				rdata = (32'(port_high) << CFG_PORT_HIGH_LSB) |
					(32'(priority_queue_count) << CFG_QUEUES_LSB) |
					(32'(policing_mode) << CFG_POLICING_LSB) |
					(32'(counters_enable) << CFG_COUNTERS_BIT);
			end else if (word[11:0] == SW_CONTROL_WORD) begin
				hit        = 1'b1;
				rdata      = ctrl;
				ctrl_write = sel.write;
			end
		end
		for (int p = 0; p < PORTS; p++) begin
			off = word - port_base[p];
			if (word >= port_base[p] && off < (32'(GROUP_COUNT) << GROUP_LSB) &&
				off[11:0] == 12'h0) begin
				case (off[GROUP_LSB+2:GROUP_LSB])
					GROUP_GENERAL: begin
						hit            = 1'b1;
						rdata          = {16'h0, o_port_state[p]};
						state_write[p] = sel.write && (grant_a || grant_b);
					end
					GROUP_RING: begin
						if (ring_redundancy_port_mask[p] || parallel_redundancy_port_mask[p]) begin
							hit   = 1'b1;
							rdata = (32'(ring_redundancy_port_mask[p]) << RING_CAP_BIT) |
								(32'(parallel_redundancy_port_mask[p]) << PARALLEL_CAP_BIT);
						end
					end
					GROUP_TIME: begin
						hit   = 1'b1;
						rdata = o_rtc_seconds;
					end
					GROUP_COUNTER: begin
						hit   = counters_enable;
						rdata = port_count[p];
					end
					GROUP_PRIORITY: begin
						hit   = 1'b1;
						rdata = POLICERS;
					end
					default: begin
						hit = 1'b0;
					end
				endcase
			end
			if (word == adapter_base[p]) begin
				hit   = 1'b1;
				rdata = {31'h0, link_sync[p]};
			end
		end
	end

	// ****************************************************************
	// Control register and derived controls
	// ****************************************************************
	logic [31:0]        next_ctrl;
	logic [port_high:0] next_cut_through;
	logic [1:0]         next_police;
	bus_rsp_type        next_rsp_a;
	bus_rsp_type        next_rsp_b;
	logic [4:0]         next_mdio;

	always_comb begin
		next_ctrl        = (ctrl_write && (grant_a || grant_b)) ? sel.writedata : ctrl;
		next_cut_through = ctrl[CTRL_CUT_THROUGH_LSB +: PORTS] &
			cut_through_port_mask[port_high:0] & ring_redundancy_port_mask[port_high:0];
		case (policing_mode)
			1: next_police = POLICE_PRIORITY;
			2: next_police = POLICE_STATIC_MAC;
			3: next_police = ctrl[CTRL_POLICE_STATIC_MAC_TABLE_BIT] ? POLICE_STATIC_MAC : POLICE_PRIORITY;
			default: next_police = POLICE_NONE;
		endcase
		next_rsp_a.waitrequest = !grant_a;
		next_rsp_a.readdata    = grant_a ? rdata : o_bus_a.readdata;
		next_rsp_b.waitrequest = !grant_b;
		next_rsp_b.readdata    = grant_b ? rdata : o_bus_b.readdata;
		next_mdio              = mdio_addr_ext_enable ? mdio_sync : mdio_addr_default;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl                <= CTRL_RESET;
			o_cut_through_ports <= '0;
			o_policing_select   <= POLICE_NONE;
			o_bus_a             <= '{waitrequest: 1'b1, readdata: 32'h0};
			o_bus_b             <= '{waitrequest: 1'b1, readdata: 32'h0};
			o_mdio_phy_addr     <= 5'h0;
		end else begin
			ctrl                <= next_ctrl;
			o_cut_through_ports <= next_cut_through;
			o_policing_select   <= next_police;
			o_bus_a             <= next_rsp_a;
			o_bus_b             <= next_rsp_b;
			o_mdio_phy_addr     <= next_mdio;
		end
	end

	// ****************************************************************
	// Real-time clock
	// ****************************************************************
	// Whole seconds only; sub-second phase is the cycle counter
	logic [31:0] rtc_cycles;
	logic [31:0] next_rtc_cycles;
	logic [31:0] next_seconds;
	logic        next_pps;
	logic        rtc_run;

	always_comb begin
		rtc_run         = rtc_autostart || ctrl[CTRL_RTC_START_BIT];
		next_rtc_cycles = rtc_cycles;
		next_seconds    = o_rtc_seconds;
		next_pps        = 1'b0;
		if (rtc_run) begin
			if (rtc_cycles == 32'(pps_period_cycles - 1)) begin
				next_rtc_cycles = 32'h0;
				next_seconds    = o_rtc_seconds + 32'h1;
				next_pps        = pps_enable;
			end else begin
				next_rtc_cycles = rtc_cycles + 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rtc_cycles    <= 32'h0;
			o_rtc_seconds <= 32'h0;
			o_pps         <= 1'b0;
		end else begin
			rtc_cycles    <= next_rtc_cycles;
			o_rtc_seconds <= next_seconds;
			o_pps         <= next_pps;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	a_grant_single: assert property (!o_bus_a.waitrequest |=> o_bus_a.waitrequest)
		else $error("slave A open two cycles");
	a_grant_b_yields: assert property (grant_a |=> o_bus_b.waitrequest)
		else $error("slave B granted beside A");
	a_unmapped_zero: assert property ((grant_a && sel.read && !hit) |=>
		o_bus_a.readdata == 32'h0)
		else $error("unmapped read not zero");
	a_cut_through_mask: assert property ((o_cut_through_ports &
		~cut_through_port_mask[port_high:0]) == '0)
		else $error("cut-through outside mask");
	a_policing_none: assert property ((policing_mode == 0) |-> o_policing_select == POLICE_NONE)
		else $error("policing active while none");
	a_pps_period: assert property (o_pps |=> !o_pps [*2])
		else $error("pulse per second too long");
	a_pps_seconds: assert property (o_pps |-> o_rtc_seconds == $past(o_rtc_seconds) + 32'h1)
		else $error("seconds not advanced with pulse");
	a_mdio_default: assert property (!mdio_addr_ext_enable |-> ##2 o_mdio_phy_addr ==
		mdio_addr_default)
		else $error("management address not default");

	c_read_a: cover property (grant_a && sel.read ##1 !o_bus_a.waitrequest);
	c_write_b: cover property (grant_b && sel.write);
	c_collide: cover property (grant_a && slave_b_enable && (i_bus_b.read || i_bus_b.write));
	c_pps: cover property (o_pps);

endmodule

// ### test/master_model.sv
// Bus master standing for the processor or the management bridge
module master_model
	import switch_cfg_pkg::*;
(
	// Clock and command
	input  wire logic                        i_clk,
	input  wire logic                        i_go,
	input  wire switch_cfg_pkg::bus_req_type i_cmd,
	// Bus
	input  wire switch_cfg_pkg::bus_rsp_type i_rsp,
	output switch_cfg_pkg::bus_req_type      o_req,
	output logic                             o_done,
	output logic [31:0]                      o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_req = '0;
	initial o_done = 1'b0;
	initial o_rdata = '0;
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		if (o_req.read | o_req.write) begin
			// Request held until the slave takes it
			if (!i_rsp.waitrequest) begin
				// Released lines go inverted so stale values never match
				o_req <= {2'b00, ~o_req.address, ~o_req.writedata};
				o_rdata <= i_rsp.readdata;
				o_done <= 1'b1;
			end
		end else if (i_go) begin
			o_req <= i_cmd;
		end
	end
endmodule

// ### test/tb.sv
// Self-checking bench of the switch configuration subsystem
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import switch_cfg_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, go_a = 1'b0, go_b = 1'b0, done_a, done_b, pulse_per_second_out;
	bus_req_type cmd = '0, req_a, req_b;
	bus_rsp_type rsp_a, rsp_b;
	logic [31:0] rd_a, rd_b, v, d, secs;
	logic [4:0] link = '0, act = '0, mext = '0, lled, aled, ctp, maddr;
	logic [4:0][15:0] pst;
	logic [1:0] psel;
	int error_cnt = 0, tests_run = 0, cyc = 0, pulses = 0;
	// Mode 1 with policer bits set 8 ns clock matches the default
	switch_cfg_subsystem #(.policing_mode(1), .pps_period_cycles(10)) i_switch_cfg_subsystem (
		.i_clk(clk), .i_arst_n(rst_n), .i_bus_a(req_a), .o_bus_a(rsp_a), .i_bus_b(req_b),
		.o_bus_b(rsp_b), .i_link_up(link), .i_activity(act), .i_mdio_addr_ext(mext),
		.o_port_state(pst), .o_link_led(lled), .o_activity_led(aled),
		.o_cut_through_ports(ctp), .o_policing_select(psel), .o_pps(pulse_per_second_out),
		.o_rtc_seconds(secs), .o_mdio_phy_addr(maddr));
	master_model i_master_model (.i_clk(clk), .i_go(go_a), .i_cmd(cmd), .i_rsp(rsp_a),
		.o_req(req_a), .o_done(done_a), .o_rdata(rd_a));
	master_model i_master_model_b (.i_clk(clk), .i_go(go_b), .i_cmd(cmd), .i_rsp(rsp_b),
		.o_req(req_b), .o_done(done_b), .o_rdata(rd_b));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Cut a hang short well past the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input bit b, input logic wr, input logic [31:0] a, input logic [31:0] dt);
		int n;
		cmd <= {~wr, wr, a, dt};
		{go_b, go_a} <= b ? 2'b10 : 2'b01;
		@(posedge clk);
		{go_b, go_a} <= 2'b00;
		n = 0;
		while (!(b ? done_b : done_a) && n < 20) begin
			@(posedge clk);
			n++;
		end
		v = b ? rd_b : rd_a;
		if (n == 20)
			error_cnt++;
	endtask
	initial begin
		void'($urandom(32'h1fb46b17));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int p = 0; p < 5; p++) begin
			xfer(0, 0, PORT_BASE_DEFAULT[p], 0);
			chk(v, 32'h0120);
			xfer(1, 0, PORT_BASE_DEFAULT[p] + 32'h1000, 0);
			chk(v, ((14 >> p) & 1) * 3);
			xfer(0, 0, PORT_BASE_DEFAULT[p] + 32'h4000, 0);
			chk(v, 1 << 7);
			d = $urandom;
			xfer(p[0], 1, PORT_BASE_DEFAULT[p], d);
			chk(pst[p], d[15:0]);
			xfer(~p[0], 0, PORT_BASE_DEFAULT[p], 0);
			chk(v, d[15:0]);
			xfer(p[0], 0, 32'h0600_0000 + PORT_BASE_DEFAULT[p], 0);
			chk(v, d[15:0]);
		end
		xfer(0, 0, 32'h0001_0000, 0);
		chk(v, 32'h0544);
		chk(psel, 2'h1);
		xfer(1, 1, 32'h0001_0001, 32'hffff_ffff);
		chk(ctp, 5'h06);
		xfer(0, 1, 32'h0001_0002, $urandom);
		xfer(0, 0, 32'h0001_0002, 0);
		chk(v, 0);
		cmd <= {2'b10, SWITCH_OFFSET, 32'h0};
		{go_b, go_a} <= 2'b11;
		@(posedge clk);
		{go_b, go_a} <= 2'b00;
		repeat (8) @(posedge clk);
		chk(rd_a, 32'h0544);
		chk(rd_b, 32'h0544);
		link <= 5'($urandom);
		act <= 5'($urandom);
		mext <= 5'($urandom);
		repeat (8) @(posedge clk);
		chk(lled, link);
		chk(aled, act);
		for (int p = 0; p < 5; p++) begin
			xfer(0, 0, PORT_BASE_DEFAULT[p] + 32'h3000, 0);
			chk(v, act[p]);
		end
		xfer(0, 0, ADAPTER_BASE_DEFAULT[1], 0);
		chk(v, link[1]);
		chk(maddr, 5'h01);
		d = secs;
		repeat (10) begin
			@(posedge clk);
			pulses += pulse_per_second_out;
		end
		chk(secs, d + 1);
		chk(pulses, 1);
		finish_test();
	end
endmodule
